// file: common/seq_matcher_params.svh
`ifndef SEQ_MATCHER_PARAMS_SVH
`define SEQ_MATCHER_PARAMS_SVH

`define CLK_HZ          100000000
`define PULSE_MIN_MS    10
`define PULSE_MIN_CYC   ((`CLK_HZ / 1000) * `PULSE_MIN_MS)

`define MASTER_DIGITS   5
`define MASTER_MOD      18'h186A0
`define STEP_MAX        16'h8000
`define STR_CHARS       64

`define ADDR_CTRL       8'h00
`define ADDR_STEP       8'h04
`define ADDR_MASTER     8'h08
`define ADDR_LOAD       8'h0C
`define ADDR_IRQ_STAT   8'h10
`define ADDR_IRQ_MASK   8'h14
`define ADDR_STR_WR     8'h18
`define ADDR_STR_LEN    8'h1C

`define CTRL_TYPE_LSB   0
`define CTRL_DIR_BIT    2
`define CTRL_SEQNR_BIT  3
`define CTRL_SEQMM_BIT  4
`define CTRL_MREP_BIT   5
`define CTRL_XREP_BIT   6
`define CTRL_PIN_BIT    7
`define CTRL_RESET      8'h08
`define STEP_RESET      16'h0001
`define MATCH_LEN_RST   7'h05
`define MISM_LEN_RST    7'h08

`define EV_MATCH        0
`define EV_MISMATCH     1
`define EV_NOREAD       2
`define EV_LOADED       3
`define EV_COUNT        4

`endif

// file: common/seq_matcher_pkg.sv
package seq_matcher_pkg;

    typedef enum logic [1:0] {
        CMP_OFF  = 2'h0,
        CMP_ON   = 2'h1,
        CMP_WILD = 2'h2,
        CMP_SEQ  = 2'h3
    } cmp_type_t;

    typedef enum logic [1:0] {
        OUT_SYMBOL   = 2'h0,
        OUT_MATCH    = 2'h1,
        OUT_MISMATCH = 2'h3
    } out_kind_t;

    typedef enum logic [1:0] {
        PIN_IDLE  = 2'h0,
        PIN_COUNT = 2'h1,
        PIN_HELD  = 2'h3
    } pin_state_t;

endpackage : seq_matcher_pkg

// file: core/sequential_master_matcher.sv
// The register offsets and the strobed register port were left to the implementer.
`include "seq_matcher_params.svh"
`timescale 1ns/1ns
`default_nettype none

module sequential_master_matcher
    import seq_matcher_pkg::*;
#(
    parameter int unsigned PULSE_CYC = `PULSE_MIN_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    input  wire logic        decValid,
    input  wire logic        decNoRead,
    input  wire logic        decNumeric,
    input  wire logic [16:0] decValue,
    input  wire logic        newMasterPin,
    output logic             outValid,
    output logic      [1:0]  outKind,
    output logic      [6:0]  outLen,
    input  wire logic [5:0]  fetchIdx,
    output logic      [7:0]  fetchChar,
    output logic             irq
);

    function automatic logic [7:0] defaultChar(input logic sel, input logic [5:0] idx);
        logic [7:0] c;
        if (!sel) begin
            case (idx)
                6'h00: c = 8'h4D;
                6'h01: c = 8'h41;
                6'h02: c = 8'h54;
                6'h03: c = 8'h43;
                6'h04: c = 8'h48;
                default: c = 8'h00;
            endcase
        end else begin
            case (idx)
                6'h00: c = 8'h4D;
                6'h01: c = 8'h49;
                6'h02: c = 8'h53;
                6'h03: c = 8'h4D;
                6'h04: c = 8'h41;
                6'h05: c = 8'h54;
                6'h06: c = 8'h43;
                6'h07: c = 8'h48;
                default: c = 8'h00;
            endcase
        end
        return c;
    endfunction : defaultChar

    // modulo step keeps the counter inside the digit range, never negative
    function automatic logic [16:0] stepValue(input logic [16:0] base,
                                              input logic [15:0] step,
                                              input logic        down);
        logic [17:0] s;
        if (!down) begin
            s = {1'b0, base} + {2'b00, step};
            if (s >= `MASTER_MOD) begin
                s = s - `MASTER_MOD;
            end
        end else if ({1'b0, base} >= {2'b00, step}) begin
            s = {1'b0, base} - {2'b00, step};
        end else begin
            s = {1'b0, base} + `MASTER_MOD - {2'b00, step};
        end
        return s[16:0];
    endfunction : stepValue

    logic [7:0]            ctrl_q;
    logic [15:0]           step_q;
    logic [16:0]           master_q;
    logic                  lastMatch_q;
    logic                  pending_q;
    logic [`EV_COUNT-1:0]  irqStat_q;
    logic [`EV_COUNT-1:0]  irqMask_q;
    logic [6:0]            matchLen_q;
    logic [6:0]            mismLen_q;
    logic [7:0]            matchStr_q [`STR_CHARS];
    logic [7:0]            mismStr_q  [`STR_CHARS];
    logic                  pinMeta_q;
    logic                  pinSync_q;
    logic [19:0]           pinCnt_q;
    pin_state_t            pinState_q;
    logic                  pinFire;
    logic [31:0]           rdata_d;

    cmp_type_t cmpType;
    logic      countDown;
    logic      cmpActive;
    logic      seqMode;
    logic      isMatch;
    logic      isMismatch;
    logic      isNoRead;
    logic      goodRead;
    logic      loadNow;
    logic      advance;
    logic [16:0] stepBase;
    logic [`EV_COUNT-1:0] events;
    logic      wrStep;
    logic      wrStr;

    assign cmpType   = cmp_type_t'(ctrl_q[`CTRL_TYPE_LSB +: 2]);
    assign countDown = ctrl_q[`CTRL_DIR_BIT];
    assign cmpActive = (cmpType != CMP_OFF);
    assign seqMode   = (cmpType == CMP_SEQ);
    assign isNoRead  = decValid && decNoRead;
    assign goodRead  = decValid && !decNoRead;
    // a pending load takes a numeric read as the new master instead of comparing it
    assign loadNow   = goodRead && pending_q && decNumeric;
    // one master only, which also covers the sequential case
    assign isMatch    = goodRead && !loadNow && cmpActive && decNumeric
                        && (decValue == master_q);
    assign isMismatch = goodRead && !loadNow && cmpActive && !isMatch;

    always_comb begin
        advance  = 1'b0;
        stepBase = master_q;
        if (seqMode) begin
            if (isMatch) begin
                advance = 1'b1;
            end else if (isNoRead) begin
                advance = ctrl_q[`CTRL_SEQNR_BIT];
            end else if (isMismatch) begin
                advance = ctrl_q[`CTRL_SEQMM_BIT] || lastMatch_q;
                if (decNumeric) begin
                    stepBase = decValue;
                end
            end
        end
    end

    assign wrStep = regWr && (regAddr == `ADDR_STEP);
    assign wrStr  = regWr && (regAddr == `ADDR_STR_WR);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `CTRL_RESET;
        end else if (regWr && regAddr == `ADDR_CTRL) begin
            ctrl_q <= regWdata[7:0];
        end
    end

    // zero and oversized steps are pulled into the legal range
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            step_q <= `STEP_RESET;
        end else if (wrStep) begin
            if (regWdata[15:0] == 16'h0000) begin
                step_q <= `STEP_RESET;
            end else if (regWdata[31:16] != 16'h0000 || regWdata[15:0] > `STEP_MAX) begin
                step_q <= `STEP_MAX;
            end else begin
                step_q <= regWdata[15:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            master_q <= 17'h00000;
        end else if (loadNow) begin
            master_q <= decValue;
        end else if (advance) begin
            master_q <= stepValue(stepBase, step_q, countDown);
        end else if (regWr && regAddr == `ADDR_MASTER) begin
            if ({15'h0000, regWdata[16:0]} < {14'h0000, `MASTER_MOD}) begin
                master_q <= regWdata[16:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lastMatch_q <= 1'b0;
        end else if (isMatch || isMismatch) begin
            lastMatch_q <= isMatch;
        end
    end

    // new-master pin: two-flop synchroniser, then a duration filter
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
        end else begin
            pinMeta_q <= newMasterPin;
            pinSync_q <= pinMeta_q;
        end
    end

    assign pinFire = (pinState_q == PIN_COUNT) && pinSync_q && (pinCnt_q == 20'(PULSE_CYC - 1));
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pinState_q <= PIN_IDLE;
            pinCnt_q   <= 20'h00000;
        end else begin
            case (pinState_q)
                PIN_IDLE: begin
                    pinCnt_q <= 20'h00000;
                    if (pinSync_q) begin
                        pinState_q <= PIN_COUNT;
                    end
                end
                PIN_COUNT: begin
                    if (!pinSync_q) begin
                        pinState_q <= PIN_IDLE;
                    end else if (pinFire) begin
                        pinState_q <= PIN_HELD;
                    end else begin
                        pinCnt_q <= pinCnt_q + 20'h00001;
                    end
                end
                PIN_HELD: begin
                    // one request per pulse however long it is held
                    if (!pinSync_q) begin
                        pinState_q <= PIN_IDLE;
                    end
                end
                default: pinState_q <= PIN_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pending_q <= 1'b0;
        end else if (pinFire && cmpActive && ctrl_q[`CTRL_PIN_BIT]) begin
            pending_q <= 1'b1;
        end else if (regWr && regAddr == `ADDR_LOAD && regWdata[0]) begin
            pending_q <= 1'b1;
        end else if (loadNow) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            matchLen_q <= `MATCH_LEN_RST;
            mismLen_q  <= `MISM_LEN_RST;
        end else if (regWr && regAddr == `ADDR_STR_LEN) begin
            matchLen_q <= (regWdata[6:0] > 7'h40) ? 7'h40 : regWdata[6:0];
            mismLen_q  <= (regWdata[14:8] > 7'h40) ? 7'h40 : regWdata[14:8];
        end
    end

    generate
        for (genvar i = 0; i < `STR_CHARS; i++) begin : gStr
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    matchStr_q[i] <= defaultChar(1'b0, 6'(i));
                    mismStr_q[i]  <= defaultChar(1'b1, 6'(i));
                end else if (wrStr && regWdata[13:8] == 6'(i)) begin
                    if (regWdata[16]) begin
                        mismStr_q[i] <= regWdata[7:0];
                    end else begin
                        matchStr_q[i] <= regWdata[7:0];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            outValid <= 1'b0;
            outKind  <= OUT_SYMBOL;
            outLen   <= 7'h00;
        end else begin
            outValid <= decValid;
            if (decValid) begin
                outKind <= OUT_SYMBOL;
                outLen  <= 7'h00;
                if (isMatch && ctrl_q[`CTRL_MREP_BIT]) begin
                    outKind <= OUT_MATCH;
                    outLen  <= matchLen_q;
                end else if (isMismatch && ctrl_q[`CTRL_XREP_BIT]) begin
                    outKind <= OUT_MISMATCH;
                    outLen  <= mismLen_q;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fetchChar <= 8'h00;
        end else begin
            fetchChar <= (outKind == OUT_MISMATCH) ? mismStr_q[fetchIdx] : matchStr_q[fetchIdx];
        end
    end
    assign events[`EV_MATCH]    = isMatch;
    assign events[`EV_MISMATCH] = isMismatch;
    assign events[`EV_NOREAD]   = isNoRead;
    assign events[`EV_LOADED]   = loadNow;

    // a new event wins over a clearing write in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irqStat_q <= '0;
        end else if (regWr && regAddr == `ADDR_IRQ_STAT) begin
            irqStat_q <= (irqStat_q & ~regWdata[`EV_COUNT-1:0]) | events;
        end else begin
            irqStat_q <= irqStat_q | events;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irqMask_q <= '0;
        end else if (regWr && regAddr == `ADDR_IRQ_MASK) begin
            irqMask_q <= regWdata[`EV_COUNT-1:0];
        end
    end

    assign irq = |(irqStat_q & irqMask_q);
    always_comb begin
        rdata_d = 32'h00000000;
        if (regAddr == `ADDR_CTRL) begin
            rdata_d = {24'h000000, ctrl_q};
        end else if (regAddr == `ADDR_STEP) begin
            rdata_d = {16'h0000, step_q};
        end else if (regAddr == `ADDR_MASTER) begin
            rdata_d = {15'h0000, master_q};
        end else if (regAddr == `ADDR_LOAD) begin
            rdata_d = {31'h00000000, pending_q};
        end else if (regAddr == `ADDR_IRQ_STAT) begin
            rdata_d = {28'h0000000, irqStat_q};
        end else if (regAddr == `ADDR_IRQ_MASK) begin
            rdata_d = {28'h0000000, irqMask_q};
        end else if (regAddr == `ADDR_STR_LEN) begin
            rdata_d = {17'h00000, mismLen_q, 1'b0, matchLen_q};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            regRdata <= 32'h00000000;
        end else begin
            regRdata <= regRd ? rdata_d : 32'h00000000;
        end
    end

endmodule : sequential_master_matcher

`default_nettype wire

// file: testbench/seq_matcher_chk.sv
`timescale 1ns/1ns
`default_nettype none
module seq_matcher_chk
    import seq_matcher_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic        decValid,
    input wire logic        outValid,
    input wire logic [1:0]  outKind,
    input wire logic [6:0]  outLen
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    chk_out_after_dec: assert property (decValid |=> outValid)
        else $error("no result after decode");
    chk_out_one_pulse: assert property (outValid && !decValid |=> !outValid)
        else $error("result pulse too long");
    chk_rd_idle_zero: assert property (!regRd |=> regRdata == 32'h0)
        else $error("read data outside read cycle");
    chk_pass_no_len: assert property (outKind == OUT_SYMBOL |-> outLen == 7'h00)
        else $error("length on pass through");
    chk_kind_legal: assert property (outKind != 2'h2)
        else $error("bad output kind");
    chk_kind_holds: assert property (!decValid |=> $stable(outKind))
        else $error("kind moved without decode");
    chk_len_holds: assert property (!decValid |=> $stable(outLen))
        else $error("length moved without decode");
    chk_len_cap: assert property (outLen <= 7'h40)
        else $error("length above cap");
endmodule : seq_matcher_chk
bind sequential_master_matcher seq_matcher_chk chk_u (
    .clk_sys(clk_sys), .resetn(resetn), .regRd(regRd), .regRdata(regRdata),
    .decValid(decValid), .outValid(outValid), .outKind(outKind), .outLen(outLen));
`default_nettype wire

// file: testbench/master_pin_driver.sv
`timescale 1ns/1ns
`default_nettype none
module master_pin_driver (
    input  wire logic clk_sys,
    output var logic  newMasterPin
);
    initial newMasterPin = 1'b0;
    // whole cycles only; a short pulse is how the qualifier gets exercised
    task automatic pulse(input int cycles);
        @(posedge clk_sys);
        newMasterPin <= 1'b1;
        repeat (cycles) @(posedge clk_sys);
        newMasterPin <= 1'b0;
    endtask : pulse
endmodule : master_pin_driver
`default_nettype wire

// file: testbench/tb_top.sv
`include "seq_matcher_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import seq_matcher_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        decValid = 1'b0;
    logic        decNoRead = 1'b0;
    logic        decNumeric = 1'b0;
    logic [16:0] decValue = 17'h0;
    logic [5:0]  fetchIdx = 6'h00;
    logic [31:0] regRdata;
    logic        newMasterPin, outValid, irq;
    logic [1:0]  outKind;
    logic [6:0]  outLen;
    logic [7:0]  fetchChar;
    int          miscompares = 0;
    int          num_checks = 0;
    always #5 clk_sys = ~clk_sys;
    sequential_master_matcher #(.PULSE_CYC(8)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .decValid(decValid),
        .decNoRead(decNoRead), .decNumeric(decNumeric), .decValue(decValue),
        .newMasterPin(newMasterPin), .outValid(outValid), .outKind(outKind),
        .outLen(outLen), .fetchIdx(fetchIdx), .fetchChar(fetchChar), .irq(irq));
    master_pin_driver pin_u (.clk_sys(clk_sys), .newMasterPin(newMasterPin));
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic chk32(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk32
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 chk32(regRdata, exp, "register");
    endtask : rd
    // nr no-read, num numeric; checks pulse and kind one cycle on
    task automatic dec(input logic nr, num, input logic [16:0] v, input logic [1:0] k);
        @(posedge clk_sys);
        decValid <= 1'b1;
        decNoRead <= nr;
        decNumeric <= num;
        decValue <= v;
        @(posedge clk_sys);
        decValid <= 1'b0;
        #1 chk32({31'h0, outValid}, 32'h1, "pulse");
        chk32({30'h0, outKind}, {30'h0, k}, "kind");
    endtask : dec
    task automatic fetch(input logic [5:0] i, input logic [7:0] c);
        @(posedge clk_sys);
        fetchIdx <= i;
        @(posedge clk_sys);
        #1 chk32({24'h0, fetchChar}, {24'h0, c}, "char");
    endtask : fetch
    task automatic t_reset;
        rd(`ADDR_CTRL, 32'h08);
        rd(`ADDR_STEP, 32'h1);
        rd(`ADDR_STR_LEN, 32'h0805);
        rd(`ADDR_LOAD, 32'h0);
        rd(8'h20, 32'h0);
        rd(`ADDR_MASTER, 32'h0);
        rd(`ADDR_IRQ_MASK, 32'h0);
        rd(`ADDR_IRQ_STAT, 32'h0);
        chk32({31'h0, irq}, 32'h0, "irq");
        $display("reset test done");
    endtask : t_reset
    task automatic t_noread;
        wr(`ADDR_CTRL, 32'h0B);
        wr(`ADDR_MASTER, 32'h1);
        dec(1'b0, 1'b1, 17'h1, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'h2);
        dec(1'b1, 1'b0, 17'h0, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'h3);
        wr(`ADDR_CTRL, 32'h03);
        dec(1'b1, 1'b0, 17'h0, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'h3);
        $display("no-read test done");
    endtask : t_noread
    task automatic t_mismatch;
        wr(`ADDR_MASTER, 32'hA);
        dec(1'b0, 1'b1, 17'hA, OUT_SYMBOL);
        dec(1'b0, 1'b0, 17'h0, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'hC);
        dec(1'b0, 1'b0, 17'h0, OUT_SYMBOL);
        dec(1'b0, 1'b1, 17'h7, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'hC);
        wr(`ADDR_CTRL, 32'h13);
        dec(1'b0, 1'b1, 17'h14, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'h15);
        dec(1'b0, 1'b0, 17'h0, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'h16);
        for (int t = 0; t < 3; t++) begin
            wr(`ADDR_CTRL, 32'h10 | t);
            dec(1'b0, 1'b1, 17'h1E, OUT_SYMBOL);
            dec(1'b0, 1'b1, 17'h16, OUT_SYMBOL);
            rd(`ADDR_MASTER, 32'h16);
        end
        $display("mismatch test done");
    endtask : t_mismatch
    task automatic t_step;
        wr(`ADDR_STEP, 32'h0);
        rd(`ADDR_STEP, 32'h1);
        wr(`ADDR_STEP, 32'h9C40);
        rd(`ADDR_STEP, 32'h8000);
        wr(`ADDR_STEP, 32'h3);
        wr(`ADDR_CTRL, 32'h03);
        wr(`ADDR_MASTER, 32'h1869E);
        dec(1'b0, 1'b1, 17'h1869E, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'h1);
        wr(`ADDR_CTRL, 32'h07);
        dec(1'b0, 1'b1, 17'h1, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'h1869E);
        wr(`ADDR_STEP, 32'h1);
        $display("step test done");
    endtask : t_step
    task automatic t_replace;
        wr(`ADDR_IRQ_STAT, 32'hF);
        wr(`ADDR_IRQ_MASK, 32'h3);
        wr(`ADDR_CTRL, 32'h61);
        wr(`ADDR_MASTER, 32'h32);
        dec(1'b0, 1'b1, 17'h32, OUT_MATCH);
        chk32({25'h0, outLen}, 32'h5, "len");
        chk32({31'h0, irq}, 32'h1, "irq");
        fetch(6'h0, 8'h4D);
        dec(1'b0, 1'b0, 17'h0, OUT_MISMATCH);
        chk32({25'h0, outLen}, 32'h8, "len");
        fetch(6'h7, 8'h48);
        wr(`ADDR_IRQ_STAT, 32'h3);
        #1 chk32({31'h0, irq}, 32'h0, "irq");
        wr(`ADDR_IRQ_MASK, 32'h0);
        dec(1'b0, 1'b1, 17'h32, OUT_MATCH);
        chk32({31'h0, irq}, 32'h0, "irq");
        rd(`ADDR_IRQ_STAT, 32'h1);
        wr(`ADDR_CTRL, 32'h01);
        dec(1'b0, 1'b1, 17'h32, OUT_SYMBOL);
        wr(`ADDR_CTRL, 32'h60);
        dec(1'b0, 1'b0, 17'h0, OUT_SYMBOL);
        wr(`ADDR_STR_LEN, 32'h7F7F);
        rd(`ADDR_STR_LEN, 32'h4040);
        wr(`ADDR_STR_WR, 32'h0000035A);
        wr(`ADDR_STR_WR, 32'h00013F21);
        fetch(6'h3, 8'h5A);
        wr(`ADDR_CTRL, 32'h41);
        dec(1'b0, 1'b0, 17'h0, OUT_MISMATCH);
        chk32({25'h0, outLen}, 32'h40, "len");
        fetch(6'h3F, 8'h21);
        $display("replace test done");
    endtask : t_replace
    task automatic t_load;
        wr(`ADDR_IRQ_STAT, 32'hF);
        wr(`ADDR_CTRL, 32'h83);
        pin_u.pulse(4);
        repeat (16) @(posedge clk_sys);
        rd(`ADDR_LOAD, 32'h0);
        pin_u.pulse(12);
        repeat (4) @(posedge clk_sys);
        rd(`ADDR_LOAD, 32'h1);
        dec(1'b0, 1'b1, 17'h4D2, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'h4D2);
        rd(`ADDR_LOAD, 32'h0);
        rd(`ADDR_IRQ_STAT, 32'h8);
        wr(`ADDR_LOAD, 32'h1);
        rd(`ADDR_LOAD, 32'h1);
        dec(1'b0, 1'b1, 17'h4D, OUT_SYMBOL);
        rd(`ADDR_MASTER, 32'h4D);
        wr(`ADDR_CTRL, 32'h03);
        pin_u.pulse(12);
        repeat (8) @(posedge clk_sys);
        rd(`ADDR_LOAD, 32'h0);
        $display("load test done");
    endtask : t_load
    // reset in mid-run with a load pending and non-default settings
    task automatic t_midreset;
        wr(`ADDR_LOAD, 32'h1);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
    endtask : t_midreset
    initial begin
        #300000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_noread();
        t_mismatch();
        t_step();
        t_replace();
        t_load();
        t_midreset();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
